// *** core/sda_scatter_unit.sv ***
`timescale 1ns/100ps
`include "sda_defines.svh"

module sda_scatter_unit
    import sda_pkg::*;
(
    input wire logic clock_i, // 20 MHz clock
    input wire logic resetn_i, // Async reset, active low
    // APB slave
    input wire logic psel_i, // Select
    input wire logic penable_i, // Access phase
    input wire logic pwrite_i, // Write
    input wire logic [4:0] paddr_i, // Byte address
    input wire logic [31:0] pwdata_i, // Write data
    output logic [31:0] prdata_o, // Read data
    output logic pready_o, // Ready
    output logic pslverr_o, // Unmapped address
    // Request message
    input wire logic msg_valid_i, // Message offered
    output logic msg_ready_o, // Message taken when valid too
    input wire logic msg_kind_i, // 0 DWord family, 1 byte family
    input wire logic msg_write_i, // 1 write, 0 read
    input wire logic [13:0] msg_desc_i, // Descriptor bits
    input wire logic msg_header_i, // Header present
    input wire logic [31:0] msg_global_off_i, // Header global offset
    input wire logic [31:0] msg_base_addr_i, // Header immediate base
    input wire logic [7:0] msg_bti_i, // Binding table index
    input wire logic [15:0] msg_exec_mask_i, // Execution mask
    input wire logic [511:0] msg_offsets_i, // Lane offsets, lane 0 low
    input wire logic [511:0] msg_wdata_i, // Lane write data
    // Memory side (cache)
    output logic mem_req_o, // Access request, held to ack
    output logic mem_we_o, // Write
    output logic [31:0] mem_addr_o, // Byte address
    output logic [1:0] mem_size_o, // 0:1 1:2 2:4 bytes
    output logic [31:0] mem_wdata_o, // Right-justified data
    output logic mem_inv_o, // Invalidate line after read
    input wire logic mem_ack_i, // Access done
    input wire logic [31:0] mem_rdata_i, // Right-justified data
    // Writeback to thread register file
    output logic wb_valid_o, // Reply offered
    input wire logic wb_ready_i, // Reply taken
    output logic [1:0] wb_regs_o, // Registers in reply
    output logic [511:0] wb_data_o, // Lane data, lane 0 low
    output logic [63:0] wb_byte_en_o, // Bytes to update
    output logic wb_error_o // Message refused
);

    // Register file
    logic ctrl_en_r;
    logic [31:0] surf_base_r;
    logic [31:0] surf_elems_r;
    logic err_r;
    logic [31:0] msg_count_r;

    // Message state
    sda_state_e state_r;
    sda_state_e state_nxt;
    sda_word_t off_r [16];
    sda_word_t wdat_r [16];
    sda_word_t rdat_r [16];
    logic [63:0] ben_r;
    logic kind_r;
    logic write_r;
    logic inv_r;
    logic stateless_r;
    logic [31:0] glob_r;
    logic [31:0] base_r;
    logic [15:0] mask_r;
    logic [4:0] lanes_r;
    logic [1:0] dsz_r;
    logic bad_r;
    logic [4:0] lane_r;

    logic accept;
    logic setup;
    logic msg_bad;
    logic [4:0] msg_lanes;
    logic [1:0] msg_dsz;
    logic [35:0] lane_byte;
    logic lane_ok;
    logic lane_on;
    logic lane_end;

    // Byte count of one lane access
    function automatic logic [35:0] size_bytes(input logic [1:0] dsz);
        case (dsz)
            `SDA_DSZ_1B: size_bytes = 36'h1;
            `SDA_DSZ_2B: size_bytes = 36'h2;
            default: size_bytes = 36'h4;
        endcase
    endfunction

    // Keeps only the low bytes of a slot
    function automatic logic [31:0] trim(input logic [31:0] d,
                                         input logic [1:0] dsz);
        case (dsz)
            `SDA_DSZ_1B: trim = {24'h0, d[7:0]};
            `SDA_DSZ_2B: trim = {16'h0, d[15:0]};
            default: trim = d;
        endcase
    endfunction

    assign setup = psel_i && !penable_i;
    assign accept = msg_valid_i && msg_ready_o;

    // Decode of the incoming descriptor
    always_comb begin
        msg_bad = 1'b0;
        msg_dsz = `SDA_DSZ_4B;
        if (msg_kind_i == SDA_KIND_DWORD) begin
            // Only codes 2 and 3 have the high bit set
            msg_lanes = msg_desc_i[`SDA_DESC_BLK_LO] ? 5'h10 : 5'h08;
            msg_bad = !msg_desc_i[`SDA_DESC_BLK_HI];
        end else begin
            msg_lanes = msg_desc_i[`SDA_DESC_LANES_BIT] ? 5'h10 : 5'h08;
            msg_dsz = msg_desc_i[`SDA_DESC_DSZ_HI:`SDA_DESC_DSZ_LO];
            if (msg_dsz == 2'h3) begin
                msg_bad = 1'b1;
            end
            if (msg_bti_i == `SDA_BTI_STATELESS) begin
                msg_bad = 1'b1; // Unsupported here
            end
        end
    end

    // Effective byte location and bounds check of the current lane
    always_comb begin
        logic [31:0] sum;
        logic [35:0] limit;
        logic [31:0] off_max;
        limit = 36'h0;
        off_max = 32'h0;
        sum = glob_r + off_r[lane_r[3:0]];
        if (kind_r == SDA_KIND_DWORD) begin
            lane_byte = {2'h0, sum, 2'h0}; // Offsets count DWords
            limit = {surf_elems_r, 4'h0}; // 16-byte elements
            off_max = `SDA_DW_OFF_MAX;
        end else begin
            lane_byte = {4'h0, sum}; // Offsets count bytes
            limit = {2'h0, surf_elems_r, 2'h0}; // 4-byte elements
            off_max = `SDA_BY_OFF_MAX;
        end
        // Stateless accesses have no surface to bound them
        lane_ok = (off_r[lane_r[3:0]] <= off_max)
                  && (stateless_r
                      || (lane_byte + size_bytes(dsz_r) <= limit));
        lane_on = mask_r[lane_r[3:0]];
        lane_end = (lane_r >= lanes_r);
    end

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SDA_IDLE: begin
                if (accept) begin
                    state_nxt = msg_bad ? SDA_REPLY : SDA_ISSUE;
                end
            end
            SDA_ISSUE: begin
                if (lane_end) begin
                    state_nxt = SDA_REPLY; // After all lanes
                end else if (lane_on && lane_ok) begin
                    state_nxt = SDA_WAIT;
                end
            end
            SDA_WAIT: begin
                if (mem_ack_i) begin
                    state_nxt = SDA_ISSUE;
                end
            end
            SDA_REPLY: begin
                if (wb_ready_i) begin
                    state_nxt = SDA_IDLE;
                end
            end
            default: state_nxt = SDA_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= SDA_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Ready only when idle and enabled; drops the cycle after a take
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            msg_ready_o <= 1'b0;
        end else begin
            msg_ready_o <= (state_nxt == SDA_IDLE) && ctrl_en_r && !accept;
        end
    end

    // Message capture; the whole payload is held for the lane walk
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            kind_r <= 1'b0;
            write_r <= 1'b0;
            inv_r <= 1'b0;
            stateless_r <= 1'b0;
            glob_r <= 32'h0;
            base_r <= 32'h0;
            mask_r <= 16'h0;
            lanes_r <= 5'h00;
            dsz_r <= 2'h0;
            bad_r <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                off_r[i] <= 32'h0;
                wdat_r[i] <= 32'h0;
            end
        end else if (accept) begin
            kind_r <= msg_kind_i;
            write_r <= msg_write_i;
            // Only the DWord family honours invalidate, reads only
            inv_r <= !msg_write_i && (msg_kind_i == SDA_KIND_DWORD)
                     && msg_desc_i[`SDA_DESC_INV_BIT];
            // Base from the header when stateless
            stateless_r <= (msg_bti_i == `SDA_BTI_STATELESS);
            base_r <= (msg_bti_i == `SDA_BTI_STATELESS) ? msg_base_addr_i
                                                        : surf_base_r;
            glob_r <= msg_header_i ? msg_global_off_i : 32'h0;
            // Upper mask half ignored for 8-lane messages
            mask_r <= (msg_lanes == 5'h10) ? msg_exec_mask_i
                                           : {8'h00, msg_exec_mask_i[7:0]};
            lanes_r <= msg_lanes;
            dsz_r <= msg_dsz;
            bad_r <= msg_bad;
            for (int i = 0; i < 16; i++) begin
                off_r[i] <= msg_offsets_i[32*i +: 32];
                wdat_r[i] <= msg_wdata_i[32*i +: 32];
            end
        end
    end

    // Lane walk counter
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lane_r <= 5'h00;
        end else if (accept) begin
            lane_r <= 5'h00;
        end else if (state_r == SDA_ISSUE && !lane_end
                     && !(lane_on && lane_ok)) begin
            lane_r <= lane_r + 5'h01; // Skipped or zero-filled lane
        end else if (state_r == SDA_WAIT && mem_ack_i) begin
            lane_r <= lane_r + 5'h01;
        end
    end

    // Memory request, held until the cache acknowledges
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h0;
            mem_size_o <= 2'h0;
            mem_wdata_o <= 32'h0;
            mem_inv_o <= 1'b0;
        end else if (state_r == SDA_ISSUE && !lane_end && lane_on
                     && lane_ok) begin
            // Raw byte move, the surface format plays no part
            mem_req_o <= 1'b1;
            mem_we_o <= write_r;
            mem_addr_o <= base_r + lane_byte[31:0];
            mem_size_o <= dsz_r;
            mem_wdata_o <= trim(wdat_r[lane_r[3:0]], dsz_r);
            mem_inv_o <= inv_r;
        end else if (mem_ack_i) begin
            mem_req_o <= 1'b0;
        end
    end

    // Reply lanes; out-of-bounds lanes never reach memory and read back as zero
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ben_r <= 64'h0;
            for (int i = 0; i < 16; i++) begin
                rdat_r[i] <= 32'h0;
            end
        end else if (accept) begin
            ben_r <= 64'h0; // Disabled lanes stay untouched
            for (int i = 0; i < 16; i++) begin
                rdat_r[i] <= 32'h0;
            end
        end else if (!write_r) begin
            if (state_r == SDA_ISSUE && !lane_end && lane_on && !lane_ok) begin
                rdat_r[lane_r[3:0]] <= 32'h0;
                ben_r[4*lane_r[3:0] +: 4] <= (dsz_r == `SDA_DSZ_1B) ? 4'h1
                    : (dsz_r == `SDA_DSZ_2B) ? 4'h3 : 4'hf;
            end else if (state_r == SDA_WAIT && mem_ack_i) begin
                // Right-justified, lane n to position n
                rdat_r[lane_r[3:0]] <= trim(mem_rdata_i, dsz_r);
                ben_r[4*lane_r[3:0] +: 4] <= (dsz_r == `SDA_DSZ_1B) ? 4'h1
                    : (dsz_r == `SDA_DSZ_2B) ? 4'h3 : 4'hf;
            end
        end
        // Writes leave ben_r clear; out-of-bounds writes dropped
    end

    // Reply valid; raised once the whole walk is done, or the cycle after the take for a refused message
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_valid_o <= 1'b0;
            wb_error_o <= 1'b0;
        end else begin
            wb_valid_o <= (state_nxt == SDA_REPLY);
            wb_error_o <= (state_nxt == SDA_REPLY) && (accept ? msg_bad
                                                             : bad_r);
        end
    end

    // Error flag: hardware set wins over software clear
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_r <= 1'b0;
        end else if (accept && msg_bad) begin
            err_r <= 1'b1;
        end else if (psel_i && penable_i && pwrite_i
                     && paddr_i == `SDA_REG_STATUS
                     && pwdata_i[`SDA_STAT_ERR_BIT]) begin
            err_r <= 1'b0;
        end
    end

    // Completed message counter
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            msg_count_r <= 32'h0;
        end else if (state_r == SDA_REPLY && wb_ready_i) begin
            msg_count_r <= msg_count_r + 32'h1;
        end
    end

    // APB writes take effect in the access phase
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_en_r <= `SDA_CTRL_RST;
            surf_base_r <= `SDA_SURF_BASE_RST;
            surf_elems_r <= `SDA_SURF_ELEMS_RST;
        end else if (psel_i && penable_i && pwrite_i) begin
            case (paddr_i)
                `SDA_REG_CTRL: ctrl_en_r <= pwdata_i[`SDA_CTRL_EN_BIT];
                // Low two bits forced clear: base is DWord aligned
                `SDA_REG_SURF_BASE: surf_base_r <= {pwdata_i[31:2], 2'h0};
                `SDA_REG_SURF_ELEMS: surf_elems_r <= pwdata_i;
                default: ;
            endcase
        end
    end

    // Read data is prepared in the setup cycle so pready can be registered
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup;
            pslverr_o <= 1'b0;
            if (setup) begin
                prdata_o <= 32'h0;
                case (paddr_i)
                    `SDA_REG_CTRL: prdata_o <= {31'h0, ctrl_en_r};
                    `SDA_REG_SURF_BASE: prdata_o <= surf_base_r;
                    `SDA_REG_SURF_ELEMS: prdata_o <= surf_elems_r;
                    `SDA_REG_STATUS:
                        prdata_o <= {30'h0, err_r, state_r != SDA_IDLE};
                    `SDA_REG_MSG_COUNT: prdata_o <= msg_count_r;
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    assign wb_byte_en_o = ben_r;
    assign wb_regs_o = write_r ? 2'h0 : (lanes_r == 5'h10) ? 2'h2 : 2'h1;

    // Flatten reply lanes
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            wb_data_o[32*i +: 32] = rdat_r[i];
        end
    end

endmodule // sda_scatter_unit

// *** core/sda_defines.svh ***
`ifndef SDA_DEFINES_SVH
`define SDA_DEFINES_SVH

// Register byte offsets on the APB side
`define SDA_REG_CTRL 5'h00
`define SDA_REG_SURF_BASE 5'h04
`define SDA_REG_SURF_ELEMS 5'h08
`define SDA_REG_STATUS 5'h0c
`define SDA_REG_MSG_COUNT 5'h10

// Register reset values
`define SDA_CTRL_RST 1'h1
`define SDA_SURF_BASE_RST 32'h0
`define SDA_SURF_ELEMS_RST 32'h0

// Field positions
`define SDA_CTRL_EN_BIT 0
`define SDA_STAT_BUSY_BIT 0
`define SDA_STAT_ERR_BIT 1
`define SDA_DESC_INV_BIT 13
`define SDA_DESC_BLK_HI 9
`define SDA_DESC_BLK_LO 8
`define SDA_DESC_DSZ_HI 11
`define SDA_DESC_DSZ_LO 10
`define SDA_DESC_LANES_BIT 8

// Descriptor codes
`define SDA_DSZ_1B 2'h0
`define SDA_DSZ_2B 2'h1
`define SDA_DSZ_4B 2'h2
`define SDA_BTI_STATELESS 8'hff

// Bounds element sizes (log2 bytes) and offset limits
`define SDA_DW_ELEM_SHIFT 4
`define SDA_BY_ELEM_SHIFT 2
`define SDA_DW_OFF_MAX 32'h03ff_ffff
`define SDA_BY_OFF_MAX 32'h0fff_ffff

`endif

// *** core/sda_pkg.sv ***
package sda_pkg;
    // Message family
    typedef enum logic {
        SDA_KIND_DWORD = 1'b0,
        SDA_KIND_BYTE = 1'b1
    } sda_kind_e;

    // One bit changes per step along idle -> issue -> wait -> issue ... -> reply -> idle, except issue -> reply
    typedef enum logic [1:0] {
        SDA_IDLE = 2'b00,
        SDA_ISSUE = 2'b01,
        SDA_WAIT = 2'b11,
        SDA_REPLY = 2'b10
    } sda_state_e;

    typedef logic [31:0] sda_word_t;
endpackage

// *** testbench/sda_mem_model.sv ***
`timescale 1ns/100ps
// Byte memory behind the cache; acks after 1 or 3 cycles
module sda_mem_model (
    input wire logic clock_i, // Clock
    input wire logic req_i, // Access request
    input wire logic we_i, // Write
    input wire logic [31:0] addr_i, // Byte address
    input wire logic [1:0] size_i, // Size code
    input wire logic [31:0] wdata_i, // Right-justified data
    input wire logic inv_i, // Invalidate hint
    input wire logic slow_i, // Answer late
    output logic ack_o, // Done pulse
    output logic [31:0] rdata_o, // Read data
    output int inv_cnt_o // Invalidating reads
);
    logic [7:0] mem [256];
    int wait_r = 0;
    initial begin
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
        ack_o = 1'b0;
        rdata_o = 32'h0;
        inv_cnt_o = 0;
    end
    // Idle data toggles so stale values show
    always @(posedge clock_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            wait_r <= wait_r + 1;
            if (wait_r >= (slow_i ? 2 : 0)) begin
                wait_r <= 0;
                ack_o <= 1'b1;
                for (int b = 0; b < 4; b++) begin
                    if (we_i && b < (1 << size_i))
                        mem[8'(addr_i + b)] <= wdata_i[8*b+:8];
                    rdata_o[8*b+:8] <= (b < (1 << size_i)) ?
                        mem[8'(addr_i + b)] : 8'h00;
                end
                if (inv_i && !we_i)
                    inv_cnt_o <= inv_cnt_o + 1;
            end
        end
    end
endmodule // sda_mem_model

// *** testbench/sda_scatter_unit_checker.sv ***
`timescale 1ns/100ps
// Watches the scatter unit's ports
module sda_scatter_unit_checker (
    input wire logic clock_i, // Clock
    input wire logic resetn_i, // Reset
    input wire logic msg_valid_i, // Offer
    input wire logic msg_ready_o, // Take
    input wire logic msg_write_i, // Write
    input wire logic msg_kind_i, // Family
    input wire logic [13:0] msg_desc_i, // Descriptor
    input wire logic [15:0] msg_exec_mask_i, // Mask
    input wire logic mem_req_o, // Request
    input wire logic mem_we_o, // Write
    input wire logic [31:0] mem_addr_o, // Address
    input wire logic [1:0] mem_size_o, // Size
    input wire logic mem_inv_o, // Invalidate
    input wire logic mem_ack_i, // Done
    input wire logic wb_valid_o, // Reply
    input wire logic wb_ready_i, // Reply taken
    input wire logic [1:0] wb_regs_o, // Registers
    input wire logic [63:0] wb_byte_en_o, // Byte enables
    input wire logic wb_error_o // Refused
);
    logic wr_r, kind_r, wide_r, inv_r;
    logic [1:0] dsz_r;
    logic [15:0] mask_r;
    logic [63:0] allow;
    // Message fields held until the next take
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {wr_r, kind_r, wide_r, inv_r, dsz_r, mask_r} <= '0;
        end else if (msg_valid_i && msg_ready_o) begin
            {wr_r, kind_r} <= {msg_write_i, msg_kind_i};
            wide_r <= msg_desc_i[8];
            {inv_r, dsz_r} <= {msg_desc_i[13], msg_desc_i[11:10]};
            mask_r <= msg_exec_mask_i;
        end
    end
    // Byte enables that an enabled lane may carry
    always_comb begin
        for (int n = 0; n < 16; n++) begin
            allow[4*n+:4] = {4{mask_r[n] && (n < 8 || wide_r)}};
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    chk_req_held: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("request moved before ack");
    chk_access_kind: assert property (
        mem_req_o |-> mem_we_o == wr_r
        && mem_inv_o == (inv_r && !wr_r && !kind_r))
        else $error("bad direction or hint");
    chk_dword_size: assert property (
        mem_req_o && !kind_r |->
        mem_size_o == 2'h2 && mem_addr_o[1:0] == 2'h0)
        else $error("dword access misaligned");
    chk_byte_size: assert property (
        mem_req_o && kind_r |-> mem_size_o == dsz_r)
        else $error("byte size mismatch");
    chk_read_regs: assert property (
        wb_valid_o && !wb_error_o |->
        wb_regs_o == (wr_r ? 2'h0 : (wide_r ? 2'h2 : 2'h1)))
        else $error("bad register count");
    chk_lane_mask: assert property (
        wb_valid_o |-> (wb_byte_en_o & ~allow) == 64'h0)
        else $error("disabled lane enabled");
    chk_wb_held: assert property (
        wb_valid_o && !wb_ready_i |=> wb_valid_o && $stable(wb_byte_en_o))
        else $error("reply moved while stalled");
    chk_reply_last: assert property (
        wb_valid_o |-> !mem_req_o)
        else $error("reply before access done");
    cover property (wb_valid_o && wide_r && !wr_r);
    cover property (mem_req_o && mem_inv_o);
    cover property (wb_valid_o && wb_error_o);
    cover property (wb_valid_o && !wb_ready_i);
endmodule // sda_scatter_unit_checker

bind sda_scatter_unit sda_scatter_unit_checker chk_u (.clock_i, .resetn_i,
    .msg_valid_i, .msg_ready_o, .msg_write_i, .msg_kind_i, .msg_desc_i,
    .msg_exec_mask_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_size_o,
    .mem_inv_o, .mem_ack_i, .wb_valid_o, .wb_ready_i, .wb_regs_o,
    .wb_byte_en_o, .wb_error_o);

// *** testbench/tb_sda_scatter_unit.sv ***
`timescale 1ns/100ps
`include "sda_defines.svh"
// Compare, count, and report a mismatch at once
`define SDA_CHECK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value at %0t: %h vs %h", $time, got, exp); \
    end \
end
module tb_sda_scatter_unit;
    typedef struct packed {
        logic kind;
        logic [13:0] desc;
        logic hdr;
        logic stl;
        logic [7:0] glob;
        logic [7:0] off;
        logic [15:0] mask;
    } sda_row_s;
    logic clock_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, msg_valid_i = 1'b0, msg_kind_i = 1'b0;
    logic msg_write_i = 1'b0, msg_header_i = 1'b0, wb_ready_i = 1'b1;
    logic slow = 1'b0, pready_o, pslverr_o, msg_ready_o, mem_req_o, mem_we_o;
    logic mem_inv_o, mem_ack_i, wb_valid_o, wb_error_o, got_err, err;
    logic [4:0] paddr_i = 5'h00;
    logic [13:0] msg_desc_i = 14'h0;
    logic [7:0] msg_bti_i = 8'h01;
    logic [15:0] msg_exec_mask_i = 16'h0;
    logic [1:0] mem_size_o, wb_regs_o, got_regs;
    logic [31:0] pwdata_i = 32'h0, msg_global_off_i = 32'h0, prdata_o, rd;
    logic [31:0] msg_base_addr_i = 32'h40, mem_addr_o, mem_wdata_o;
    logic [31:0] mem_rdata_i;
    logic [511:0] msg_offsets_i = '0, msg_wdata_i = '0, wb_data_o, got_data;
    logic [63:0] wb_byte_en_o, got_be;
    int comparisons = 0, miscompares = 0, inv_cnt;
    // Ordinary reads, then refused codes; base 0x40, 4 elements
    sda_row_s rows [11] = '{
        '{1'b0, 14'h0200, 1'b1, 1'b0, 8'h02, 8'h01, 16'h00ff},
        '{1'b0, 14'h0200, 1'b0, 1'b0, 8'h05, 8'h00, 16'h005a},
        '{1'b0, 14'h0300, 1'b1, 1'b0, 8'h04, 8'h00, 16'hffff},
        '{1'b0, 14'h2200, 1'b1, 1'b0, 8'h00, 8'h08, 16'hff81},
        '{1'b0, 14'h0200, 1'b1, 1'b1, 8'h00, 8'h14, 16'h0003},
        '{1'b1, 14'h0000, 1'b1, 1'b0, 8'h03, 8'h04, 16'h00ff},
        '{1'b1, 14'h0500, 1'b1, 1'b0, 8'h00, 8'h02, 16'hffff},
        '{1'b1, 14'h0800, 1'b1, 1'b0, 8'h01, 8'h0a, 16'h00ff},
        '{1'b0, 14'h0100, 1'b1, 1'b0, 8'h00, 8'h00, 16'h00ff},
        '{1'b1, 14'h0c00, 1'b1, 1'b0, 8'h00, 8'h00, 16'h00ff},
        '{1'b1, 14'h0000, 1'b1, 1'b1, 8'h00, 8'h00, 16'h00ff}};
    sda_scatter_unit dut_u (.clock_i, .resetn_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .msg_valid_i, .msg_ready_o, .msg_kind_i, .msg_write_i, .msg_desc_i,
        .msg_header_i, .msg_global_off_i, .msg_base_addr_i, .msg_bti_i,
        .msg_exec_mask_i, .msg_offsets_i, .msg_wdata_i, .mem_req_o, .mem_we_o,
        .mem_addr_o, .mem_size_o, .mem_wdata_o, .mem_inv_o, .mem_ack_i,
        .mem_rdata_i, .wb_valid_o, .wb_ready_i, .wb_regs_o, .wb_data_o,
        .wb_byte_en_o, .wb_error_o);
    sda_mem_model mem_u (.clock_i, .req_i(mem_req_o), .we_i(mem_we_o),
        .addr_i(mem_addr_o), .size_i(mem_size_o), .wdata_i(mem_wdata_o),
        .inv_i(mem_inv_o), .slow_i(slow), .ack_o(mem_ack_i),
        .rdata_o(mem_rdata_i), .inv_cnt_o(inv_cnt));
    // Free-running clock
    always #25 clock_i = ~clock_i;
    function automatic logic [7:0] pat(input int a);
        return 8'(a) ^ 8'ha5;
    endfunction
    // One APB transfer; waits for pready, takes data at that edge
    task automatic apb(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd);
        int t = 0;
        @(posedge clock_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, wd};
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (!pready_o && ++t < 20);
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    // Offer a message, then wait for the reply handshake
    task automatic send(input sda_row_s r, input logic wr);
        int t = 0;
        @(posedge clock_i);
        {msg_valid_i, msg_kind_i, msg_write_i} <= {1'b1, r.kind, wr};
        {msg_desc_i, msg_header_i} <= {r.desc, r.hdr};
        msg_global_off_i <= 32'(r.glob);
        msg_bti_i <= r.stl ? `SDA_BTI_STATELESS : 8'h01;
        msg_exec_mask_i <= r.mask;
        for (int n = 0; n < 16; n++) begin
            msg_offsets_i[32*n+:32] <= 32'(r.off) + 32'(n);
            msg_wdata_i[32*n+:32] <= 32'ha1b2c3d0 | 32'(n);
        end
        do @(posedge clock_i); while (!msg_ready_o && ++t < 50);
        msg_valid_i <= 1'b0;
        do @(posedge clock_i);
        while (!(wb_valid_o && wb_ready_i) && ++t < 400);
        {got_err, got_regs, got_be, got_data} =
            {wb_error_o, wb_regs_o, wb_byte_en_o, wb_data_o};
        `SDA_CHECK(wb_valid_o, 1'b1)
    endtask
    // Expected reply, lane by lane
    task automatic check_reply(input sda_row_s r);
        int sz, eff, lim;
        logic bad, on;
        logic [3:0] be;
        logic [31:0] d, bm;
        bad = r.kind ? (r.desc[11:10] == 2'h3 || r.stl) : !r.desc[9];
        sz = r.kind ? 1 << r.desc[11:10] : 4;
        lim = r.stl ? 1024 : (r.kind ? 16 : 64);
        `SDA_CHECK(got_err, bad)
        for (int n = 0; n < 16; n++) begin
            on = !bad && r.mask[n] && (n < 8 || r.desc[8]);
            eff = (r.hdr ? r.glob : 0) + r.off + n;
            eff = r.kind ? eff : 4 * eff;
            be = on ? 4'((1 << sz) - 1) : 4'h0;
            bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            for (int b = 0; b < 4; b++) d[8*b+:8] = pat(64 + eff + b);
            if (eff + sz > lim) d = 32'h0;
            `SDA_CHECK(got_be[4*n+:4], be)
            `SDA_CHECK(got_data[32*n+:32] & bm, d & bm)
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        #2000000;
        miscompares++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        apb(1'b0, `SDA_REG_CTRL, 32'h0);
        `SDA_CHECK(rd, 32'h1)
        apb(1'b0, `SDA_REG_SURF_ELEMS, 32'h0);
        `SDA_CHECK(rd, 32'h0)
        apb(1'b0, 5'h14, 32'h0);
        `SDA_CHECK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, `SDA_REG_SURF_BASE, 32'h40);
        apb(1'b1, `SDA_REG_SURF_ELEMS, 32'h4);
        apb(1'b1, `SDA_REG_CTRL, 32'h0);
        repeat (2) @(posedge clock_i);
        `SDA_CHECK(msg_ready_o, 1'b0)
        apb(1'b1, `SDA_REG_CTRL, 32'h1);
        foreach (rows[i]) begin
            send(rows[i], 1'b0);
            check_reply(rows[i]);
        end
        `SDA_CHECK(inv_cnt, 2)
        apb(1'b0, `SDA_REG_STATUS, 32'h0);
        `SDA_CHECK(rd[1], 1'b1)
        // Lane 0 lands in the last dword, lane 1 falls outside
        send('{1'b0, 14'h0200, 1'b1, 1'b0, 8'h0f, 8'h00, 16'h0003}, 1'b1);
        `SDA_CHECK({got_regs, got_be}, 66'h0)
        `SDA_CHECK({mem_u.mem[8'h7f], mem_u.mem[8'h7c]}, 16'ha1d0)
        `SDA_CHECK(mem_u.mem[8'h80], pat(8'h80))
        send('{1'b1, 14'h0000, 1'b1, 1'b0, 8'h00, 8'h02, 16'h0001}, 1'b1);
        `SDA_CHECK(mem_u.mem[8'h42], 8'hd0)
        `SDA_CHECK(mem_u.mem[8'h43], pat(67))
        // Slow memory and a stalled reply
        {slow, wb_ready_i} <= 2'b10;
        fork
            send(rows[0], 1'b0);
            begin
                repeat (60) @(posedge clock_i);
                wb_ready_i <= 1'b1;
            end
        join
        check_reply(rows[0]);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        apb(1'b0, `SDA_REG_SURF_BASE, 32'h0);
        `SDA_CHECK(rd, 32'h0)
        complete_run();
    end
endmodule // tb_sda_scatter_unit
